// ---- rtl/fsec_pkg.sv ----
// Purpose: Constants for the finger sensor event configuration block
// Assumes: 8-bit register port, 7-bit register addresses
// Notes:   Threshold, orientation and window offsets are local picks
`default_nettype none
package fsec_pkg;
   // =========================================================
   // Register offsets
   localparam logic [6:0] OFS_ENGINE_TWO   = 7'h61;
   localparam logic [6:0] OFS_LIN_REGION   = 7'h73;
   localparam logic [6:0] OFS_MOTION_IRQ   = 7'h74;
   localparam logic [6:0] OFS_FINGER_CTRL  = 7'h75;
   localparam logic [6:0] OFS_FINGER_THR   = 7'h76;
   localparam logic [6:0] OFS_ORIENT       = 7'h77;
   localparam logic [6:0] OFS_QUAL_THR     = 7'h78;
   localparam logic [6:0] OFS_REFLECT      = 7'h79;
   localparam logic [6:0] OFS_FINGER_STATE = 7'h7A;
   localparam logic [6:0] OFS_CLICK_CTRL   = 7'h7B;
   localparam logic [6:0] OFS_HOLD_TIME    = 7'h7C;
   localparam logic [6:0] OFS_DCLICK_WIN   = 7'h7D;
   localparam logic [6:0] OFS_CLICK_LIMIT  = 7'h7E;
   localparam logic [6:0] OFS_CLICK_FLAGS  = 7'h7F;
   // =========================================================
   // Reset values
   localparam logic [7:0] RST_ENGINE_TWO   = 8'h00;
   localparam logic [7:0] RST_LIN_REGION   = 8'h02;
   localparam logic [7:0] RST_MOTION_IRQ   = 8'h00;
   localparam logic [7:0] RST_FINGER_CTRL  = 8'hFA;
   localparam logic [7:0] RST_FINGER_THR   = 8'h80;
   localparam logic [7:0] RST_ORIENT       = 8'h00;
   localparam logic [7:0] RST_QUAL_THR     = 8'h40;
   localparam logic [7:0] RST_CLICK_CTRL   = 8'h25;
   localparam logic [7:0] RST_HOLD_TIME    = 8'h45;
   localparam logic [7:0] RST_DCLICK_WIN   = 8'h20;
   localparam logic [7:0] RST_CLICK_LIMIT  = 8'h19;
   // =========================================================
   // Field positions
   localparam int BIT_AXIS_SWAP  = 7;
   localparam int BIT_VERT_INV   = 6;
   localparam int BIT_HORIZ_INV  = 5;
   localparam int BIT_SINGLE     = 0;
   localparam int BIT_DOUBLE     = 1;
   localparam int BIT_HOLD       = 2;
   localparam int BIT_QUAL_EN    = 0;
   localparam int BIT_CUTOFF_EN  = 1;
   localparam int BIT_GRADIENT   = 2;
   // Cut-off threshold unit in shutter counts, shift of 8
   localparam int CUTOFF_SHIFT   = 8;
   // Time unit of click timing fields, in clock cycles
   localparam int TICK_CYCLES    = 20000;
endpackage : fsec_pkg
`default_nettype wire

// ---- rtl/fsec_hyst.sv ----
// Purpose: Hysteresis counter declaring a level stable after count+1 samples
// Assumes: sample pulse marks one new measurement
// Notes:   Count of zero declares on the first qualifying sample
`default_nettype none
module fsec_hyst
(
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       reset,
   // Measurement
   input  wire logic       sample,
   input  wire logic       cond_on,
   input  wire logic [1:0] on_count,
   input  wire logic [1:0] off_count,
   // State
   output logic            state_ff
);
   logic [1:0] cnt_ff;
   logic       against;
   logic [1:0] limit;

   // Sample disagreeing with the held state advances the counter
   assign against = cond_on != state_ff;
   assign limit   = state_ff ? off_count : on_count;

   // Flip only after the programmed run of disagreeing samples
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         cnt_ff   <= 2'h0;
         state_ff <= 1'b0;
      end
      else if (sample)
      begin
         if (!against)
            cnt_ff <= 2'h0;
         else if (cnt_ff >= limit)
         begin
            cnt_ff   <= 2'h0;
            state_ff <= ~state_ff;
         end
         else
            cnt_ff <= cnt_ff + 2'h1;
      end
   end
endmodule : fsec_hyst
`default_nettype wire

// ---- rtl/fsec_core.sv ----
// Purpose: Finger sensor event configuration, presence and soft clicks
// Assumes: 8-bit register port synchronous to clk; frame pulses
// Notes:   Deltas are signed 8-bit; click time unit is TICK cycles
//
// Behaviour
// - Motion reported only when |dx|+|dy| exceeds 3-bit threshold.
// - Cut-off enabled: suppress motion while shutter below nibble*256.
// - Presence on-hysteresis bits 3:2, off-hysteresis bits 1:0.
// - Presence decided by reflectivity against 8-bit threshold.
// - Axis swap exchanges reported X and Y deltas.
// - Vertical invert negates only reported Y.
// - Horizontal invert negates only reported X.
// - Quality enable adds quality compare; quality threshold resets 0x40.
// - Measured reflectivity stored in an 8-bit register.
// - Reflect hysteresis bound is eight times status bits 7:4.
// - Quality hysteresis bound is four times status bits 3:1.
// - Status bit 0 reads one while finger present.
// - Click kinds detected only while enable bits 0..2 set; reset 0x25.
// - Hold timer resets when motion exceeds twice the bits 6:4 level.
// - Hold fires after touch lasts the programmed hold time.
// - Second click within double-click window is a double click.
// - Single click valid only if delta sum below limit.
// - Flags: bit0 single, bit1 double, bit2 hold.
// - Linear region offset is a 2-bit field, max three.
// - Linear region gradient one when bit clear, two when set.
`default_nettype none
module fsec_core
   import fsec_pkg::*;
#(
   parameter int TICK = TICK_CYCLES
)
(
   // Clock and reset
   input  wire logic              clk,
   input  wire logic              reset,
   // Register port
   input  wire logic              reg_wr,
   input  wire logic              reg_rd,
   input  wire logic [6:0]        reg_addr,
   input  wire logic [7:0]        reg_wdata,
   output logic      [7:0]        reg_rdata_ff,
   // Frame measurements
   input  wire logic              frame_valid,
   input  wire logic signed [7:0] raw_dx,
   input  wire logic signed [7:0] raw_dy,
   input  wire logic [15:0]       shutter,
   input  wire logic [7:0]        reflect_meas,
   input  wire logic [7:0]        quality_meas,
   input  wire logic [3:0]        reflect_hyst_in,
   input  wire logic [2:0]        quality_hyst_in,
   // Reported motion and events
   output logic signed [7:0]      out_dx_ff,
   output logic signed [7:0]      out_dy_ff,
   output logic [1:0]             linear_region_offset_ff,
   output logic [1:0]             linear_region_gradient_ff,
   output logic                   irq_ff
);
   // =========================================================
   // Registers
   logic [7:0] engine_config_two_ff, lin_region_ff, motion_irq_ff;
   logic [7:0] finger_ctrl_ff, finger_thr_ff, orient_ff, qual_thr_ff;
   logic [7:0] reflect_ff, click_ctrl_ff, hold_time_ff;
   logic [7:0] dclick_win_ff, click_limit_ff, click_flags_ff;
   logic [3:0] reflect_hyst_ff;
   logic [2:0] quality_hyst_ff;
   logic       finger_present_flag;

   // Write decode
   wire wr_engine = reg_wr && reg_addr == OFS_ENGINE_TWO;
   wire wr_lin    = reg_wr && reg_addr == OFS_LIN_REGION;
   wire wr_motion = reg_wr && reg_addr == OFS_MOTION_IRQ;
   wire wr_fctrl  = reg_wr && reg_addr == OFS_FINGER_CTRL;
   wire wr_fthr   = reg_wr && reg_addr == OFS_FINGER_THR;
   wire wr_orient = reg_wr && reg_addr == OFS_ORIENT;
   wire wr_qthr   = reg_wr && reg_addr == OFS_QUAL_THR;
   wire wr_refl   = reg_wr && reg_addr == OFS_REFLECT;
   wire wr_cctrl  = reg_wr && reg_addr == OFS_CLICK_CTRL;
   wire wr_hold   = reg_wr && reg_addr == OFS_HOLD_TIME;
   wire wr_dwin   = reg_wr && reg_addr == OFS_DCLICK_WIN;
   wire wr_limit  = reg_wr && reg_addr == OFS_CLICK_LIMIT;
   wire wr_flags  = reg_wr && reg_addr == OFS_CLICK_FLAGS;

   // Plain configuration storage
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         engine_config_two_ff <= RST_ENGINE_TWO;
         lin_region_ff        <= RST_LIN_REGION;
         motion_irq_ff        <= RST_MOTION_IRQ;
         finger_ctrl_ff       <= RST_FINGER_CTRL;
         finger_thr_ff        <= RST_FINGER_THR;
         orient_ff            <= RST_ORIENT;
         qual_thr_ff          <= RST_QUAL_THR;
         click_ctrl_ff        <= RST_CLICK_CTRL;
         hold_time_ff         <= RST_HOLD_TIME;
         dclick_win_ff        <= RST_DCLICK_WIN;
         click_limit_ff       <= RST_CLICK_LIMIT;
      end
      else
      begin
         if (wr_engine) engine_config_two_ff <= reg_wdata;
         if (wr_lin)    lin_region_ff  <= {5'h00, reg_wdata[2:0]};
         if (wr_motion) motion_irq_ff  <= {5'h00, reg_wdata[2:0]};
         if (wr_fctrl)  finger_ctrl_ff <= reg_wdata;
         if (wr_fthr)   finger_thr_ff  <= reg_wdata;
         if (wr_orient) orient_ff      <= {reg_wdata[7:5], 5'h00};
         if (wr_qthr)   qual_thr_ff    <= reg_wdata;
         if (wr_cctrl)  click_ctrl_ff  <= {1'b0, reg_wdata[6:4], 1'b0,
                                           reg_wdata[2:0]};
         if (wr_hold)   hold_time_ff   <= reg_wdata;
         if (wr_dwin)   dclick_win_ff  <= reg_wdata;
         if (wr_limit)  click_limit_ff <= reg_wdata;
      end
   end

   // =========================================================
   // Orientation and motion gating
   logic signed [7:0] sw_x, sw_y, or_x, or_y;
   logic [7:0]        abs_x, abs_y;
   logic [8:0]        delta_sum;
   logic              cutoff_active, motion_ok;

   assign sw_x = orient_ff[BIT_AXIS_SWAP] ? raw_dy : raw_dx;
   assign sw_y = orient_ff[BIT_AXIS_SWAP] ? raw_dx : raw_dy;
   assign or_x = orient_ff[BIT_HORIZ_INV] ? -sw_x : sw_x;
   assign or_y = orient_ff[BIT_VERT_INV]  ? -sw_y : sw_y;
   assign abs_x = raw_dx[7] ? 8'(-raw_dx) : 8'(raw_dx);
   assign abs_y = raw_dy[7] ? 8'(-raw_dy) : 8'(raw_dy);
   assign delta_sum = {1'b0, abs_x} + {1'b0, abs_y};
   // Cut-off only counts once engine config bit 1 enables it
   assign cutoff_active = engine_config_two_ff[BIT_CUTOFF_EN] &&
      (shutter < ({12'h000, finger_ctrl_ff[7:4]} << CUTOFF_SHIFT));
   assign motion_ok = !cutoff_active &&
      (delta_sum > {6'h00, motion_irq_ff[2:0]});

   // Reported deltas hold until the next qualifying frame
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         out_dx_ff <= 8'sh00;
         out_dy_ff <= 8'sh00;
      end
      else if (frame_valid && motion_ok)
      begin
         out_dx_ff <= or_x;
         out_dy_ff <= or_y;
      end
   end

   // Quantization region settings passed to the delta path
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         linear_region_offset_ff   <= 2'h0;
         linear_region_gradient_ff <= 2'h1;
      end
      else
      begin
         linear_region_offset_ff   <= lin_region_ff[1:0];
         linear_region_gradient_ff <= lin_region_ff[BIT_GRADIENT]
                                      ? 2'h2 : 2'h1;
      end
   end

   // =========================================================
   // Finger presence
   logic [7:0] reflect_bound, quality_bound;
   logic       reflect_hit, quality_hit, presence_cond;

   assign reflect_bound = {1'b0, reflect_hyst_ff, 3'h0};
   assign quality_bound = {3'h0, quality_hyst_ff, 2'h0};
   // Bound widens the band around the threshold once present
   assign reflect_hit = finger_present_flag
      ? ({1'b0, reflect_meas} + {1'b0, reflect_bound} >= {1'b0, finger_thr_ff})
      : (reflect_meas >= finger_thr_ff);
   assign quality_hit = finger_present_flag
      ? ({1'b0, quality_meas} + {1'b0, quality_bound} >= {1'b0, qual_thr_ff})
      : (quality_meas >= qual_thr_ff);
   assign presence_cond = reflect_hit &&
      (!engine_config_two_ff[BIT_QUAL_EN] || quality_hit);

   // Stored measurement and latched hysteresis bounds
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         reflect_ff      <= 8'h00;
         reflect_hyst_ff <= 4'h0;
         quality_hyst_ff <= 3'h0;
      end
      else
      begin
         if (frame_valid)
         begin
            reflect_ff      <= reflect_meas;
            reflect_hyst_ff <= reflect_hyst_in;
            quality_hyst_ff <= quality_hyst_in;
         end
         else if (wr_refl)
            reflect_ff <= reg_wdata;
      end
   end

   fsec_hyst u_presence
   (
      .clk       (clk),
      .reset     (reset),
      .sample    (frame_valid),
      .cond_on   (presence_cond),
      .on_count  (finger_ctrl_ff[3:2]),
      .off_count (finger_ctrl_ff[1:0]),
      .state_ff  (finger_present_flag)
   );

   // =========================================================
   // Soft clicks
   logic [15:0] tick_ff;
   logic [7:0]  touch_ff, gap_ff, move_ff;
   logic        was_on_ff, pending_ff, held_ff, tick;
   logic [2:0]  nxt_events;
   logic        release_e, click_ok, is_double;

   assign tick      = tick_ff == 16'(TICK - 1);
   assign release_e = was_on_ff && !finger_present_flag;
   assign click_ok  = release_e && !held_ff &&
                      move_ff < click_limit_ff;
   assign is_double = pending_ff && gap_ff <= dclick_win_ff;
   assign nxt_events[BIT_SINGLE] = click_ok && !is_double &&
                                   click_ctrl_ff[BIT_SINGLE];
   assign nxt_events[BIT_DOUBLE] = click_ok && is_double &&
                                   click_ctrl_ff[BIT_DOUBLE];
   assign nxt_events[BIT_HOLD]   = finger_present_flag && !held_ff &&
      touch_ff >= hold_time_ff && click_ctrl_ff[BIT_HOLD];

   // Touch, gap and motion accumulation
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         tick_ff <= 16'h0000;
         touch_ff <= 8'h00;
         gap_ff <= 8'h00;
         move_ff <= 8'h00;
         was_on_ff <= 1'b0;
         pending_ff <= 1'b0;
         held_ff <= 1'b0;
      end
      else
      begin
         tick_ff   <= tick ? 16'h0000 : tick_ff + 16'h0001;
         was_on_ff <= finger_present_flag;
         if (!finger_present_flag)
         begin
            touch_ff <= 8'h00;
            held_ff  <= 1'b0;
         end
         else
         begin
            // Large motion restarts the hold timer
            if (frame_valid && delta_sum > {5'h00, click_ctrl_ff[6:4], 1'b0})
               touch_ff <= 8'h00;
            else if (tick && touch_ff != 8'hFF)
               touch_ff <= touch_ff + 8'h01;
            if (nxt_events[BIT_HOLD])
               held_ff <= 1'b1;
         end
         if (finger_present_flag && !was_on_ff)
            move_ff <= 8'h00;
         else if (frame_valid && finger_present_flag)
            move_ff <= (move_ff + delta_sum[7:0] < move_ff) ? 8'hFF
                       : move_ff + delta_sum[7:0];
         if (click_ok)
         begin
            pending_ff <= !is_double;
            gap_ff     <= 8'h00;
         end
         else if (tick && gap_ff != 8'hFF)
            gap_ff <= gap_ff + 8'h01;
      end
   end

   // Sticky flags: a new event wins over a host clear
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         click_flags_ff <= 8'h00;
         irq_ff         <= 1'b0;
      end
      else
      begin
         click_flags_ff <= {5'h00, nxt_events |
            (wr_flags ? reg_wdata[2:0] & click_flags_ff[2:0]
                      : click_flags_ff[2:0])};
         irq_ff <= |nxt_events;
      end
   end

   // =========================================================
   // Read path
   logic [7:0] rd_mux;
   always_comb
   begin
      case (reg_addr)
         OFS_ENGINE_TWO:   rd_mux = engine_config_two_ff;
         OFS_LIN_REGION:   rd_mux = lin_region_ff;
         OFS_MOTION_IRQ:   rd_mux = motion_irq_ff;
         OFS_FINGER_CTRL:  rd_mux = finger_ctrl_ff;
         OFS_FINGER_THR:   rd_mux = finger_thr_ff;
         OFS_ORIENT:       rd_mux = orient_ff;
         OFS_QUAL_THR:     rd_mux = qual_thr_ff;
         OFS_REFLECT:      rd_mux = reflect_ff;
         OFS_FINGER_STATE: rd_mux = {reflect_hyst_ff, quality_hyst_ff,
                                     finger_present_flag};
         OFS_CLICK_CTRL:   rd_mux = click_ctrl_ff;
         OFS_HOLD_TIME:    rd_mux = hold_time_ff;
         OFS_DCLICK_WIN:   rd_mux = dclick_win_ff;
         OFS_CLICK_LIMIT:  rd_mux = click_limit_ff;
         OFS_CLICK_FLAGS:  rd_mux = click_flags_ff;
         default:          rd_mux = 8'h00;
      endcase
   end

   always_ff @(posedge clk)
   begin
      if (reset)
         reg_rdata_ff <= 8'h00;
      else if (reg_rd)
         reg_rdata_ff <= rd_mux;
   end

   // =========================================================
   // Checks
   chk_motion_gate: assert property (@(posedge clk) disable iff (reset)
      frame_valid && !motion_ok |=> $stable(out_dx_ff))
      else $error("motion reported below threshold");
   chk_swap_path: assert property (@(posedge clk) disable iff (reset)
      frame_valid && motion_ok && orient_ff[7:5] == 3'b100
      |=> out_dx_ff == $past(raw_dy) && out_dy_ff == $past(raw_dx))
      else $error("axis swap wrong");
   chk_vert_inv: assert property (@(posedge clk) disable iff (reset)
      frame_valid && motion_ok && orient_ff[7:5] == 3'b010
      |=> out_dy_ff == -$past(raw_dy) && out_dx_ff == $past(raw_dx))
      else $error("vertical invert wrong");
   chk_horiz_inv: assert property (@(posedge clk) disable iff (reset)
      frame_valid && motion_ok && orient_ff[7:5] == 3'b001
      |=> out_dx_ff == -$past(raw_dx) && out_dy_ff == $past(raw_dy))
      else $error("horizontal invert wrong");
   chk_reflect_store: assert property (@(posedge clk) disable iff (reset)
      frame_valid |=> reflect_ff == $past(reflect_meas))
      else $error("reflectivity not stored");
   chk_flag_sticky: assert property (@(posedge clk) disable iff (reset)
      click_flags_ff[0] && !wr_flags |=> click_flags_ff[0])
      else $error("click flag lost");
   chk_irq_cause: assert property (@(posedge clk) disable iff (reset)
      irq_ff |-> click_flags_ff[2:0] != 3'h0)
      else $error("interrupt without event");
   chk_enable_gate: assert property (@(posedge clk) disable iff (reset)
      !click_ctrl_ff[BIT_DOUBLE] |-> !nxt_events[BIT_DOUBLE])
      else $error("disabled double click fired");
   chk_gradient: assert property (@(posedge clk) disable iff (reset)
      lin_region_ff[BIT_GRADIENT] ##1 lin_region_ff[BIT_GRADIENT]
      |-> linear_region_gradient_ff == 2'h2)
      else $error("gradient wrong");
   cov_single: cover property (@(posedge clk) nxt_events[BIT_SINGLE]);
   cov_double: cover property (@(posedge clk) nxt_events[BIT_DOUBLE]);
   cov_hold:   cover property (@(posedge clk) nxt_events[BIT_HOLD]);
   cov_finger: cover property (@(posedge clk) $rose(finger_present_flag));
endmodule : fsec_core
`default_nettype wire

// ---- sim/fsec_host_model.sv ----
// Purpose: Host side of the register port, single byte accesses
// Assumes: Requests change on the falling clock edge
// Notes:   Each strobe covers exactly one rising edge
`default_nettype none
module fsec_host_model
(
   // Clock
   input  wire logic       clk,
   // Register port
   output logic            reg_wr,
   output logic            reg_rd,
   output logic [6:0]      reg_addr,
   output logic [7:0]      reg_wdata,
   input  wire logic [7:0] reg_rdata_ff
);
   timeunit 1ns;
   timeprecision 1ns;
   // ==================================================
   // Idle bus at time zero
   initial
   begin
      reg_wr    = 1'b0;
      reg_rd    = 1'b0;
      reg_addr  = 7'h00;
      reg_wdata = 8'h00;
   end
   // Write; data inverted afterwards so no stale byte looks valid
   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      @(negedge clk);
      reg_addr  = a;
      reg_wdata = d;
      reg_wr    = 1'b1;
      @(negedge clk);
      reg_wr    = 1'b0;
      reg_wdata = ~d;
   endtask : wr
   // Read; the registered byte is taken at the falling edge after the strobe
   task automatic rd(input logic [6:0] a, output logic [7:0] d);
      @(negedge clk);
      reg_addr = a;
      reg_rd   = 1'b1;
      @(negedge clk);
      reg_rd   = 1'b0;
      d        = reg_rdata_ff;
   endtask : rd
endmodule : fsec_host_model
`default_nettype wire

// ---- sim/test_finger_sensor_event_config.sv ----
// Purpose: Self-checking bench for the finger sensor event block
// Assumes: TICK of 4 keeps click timing short
// Notes:   Inputs change on the falling edge
`default_nettype none
module test_finger_sensor_event_config
   import fsec_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic              clk = 1'b0;
   logic              reset = 1'b1;
   logic              reg_wr, reg_rd, irq, fv = 1'b0;
   logic [6:0]        reg_addr;
   logic [7:0]        reg_wdata, rdata, reg_rdata_ff, refl = 8'h00;
   logic signed [7:0] dx = 8'h00, dy = 8'h00, out_dx, out_dy;
   logic [15:0]       shut = 16'hFFFF;
   logic [7:0]        qual = 8'h40;
   logic [1:0]        lro, lrg;
   int                err_total = 0, cmp_count = 0, irq_n = 0;
   // ==================================================
   // Clock, reset, irq pulse counter
   always #25 clk = ~clk;
   initial repeat (5) @(negedge clk) reset = 1'b1;
   always @(negedge clk) if (irq === 1'b1) irq_n++;
   fsec_core #(.TICK(4)) dut (.clk(clk), .reset(reset), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_rdata_ff(reg_rdata_ff), .frame_valid(fv), .raw_dx(dx),
      .raw_dy(dy), .shutter(shut), .reflect_meas(refl),
      .quality_meas(qual), .reflect_hyst_in(4'h3),
      .quality_hyst_in(3'h5), .out_dx_ff(out_dx), .out_dy_ff(out_dy),
      .linear_region_offset_ff(lro), .linear_region_gradient_ff(lrg),
      .irq_ff(irq));
   fsec_host_model host (.clk(clk), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_rdata_ff(reg_rdata_ff));
   // ==================================================
   // Shared helpers
   task automatic chk(input string nm, input logic [7:0] s, e);
      cmp_count++;
      if (s !== e)
      begin
         err_total++;
         $display("Error %s expected %h seen %h", nm, e, s);
      end
   endtask : chk
   task automatic rc(input logic [6:0] a, input logic [7:0] e);
      host.rd(a, rdata);
      chk($sformatf("reg %h", a), rdata, e);
   endtask : rc
   // One frame pulse, then time for the registered outputs
   task automatic frame(input logic signed [7:0] x, y,
                        input logic [15:0] sh, input logic [7:0] rf);
      @(negedge clk);
      dx   = x;
      dy   = y;
      shut = sh;
      refl = rf;
      fv   = 1'b1;
      @(negedge clk);
      fv   = 1'b0;
      repeat (2) @(negedge clk);
   endtask : frame
   task automatic outs(input logic signed [7:0] x, y);
      chk("out_dx", out_dx, x);
      chk("out_dy", out_dy, y);
   endtask : outs
   // ==================================================
   // Scenarios
   task automatic t_reset;
      logic [6:0] a [9] = '{7'h74, 7'h75, 7'h78, 7'h7A, 7'h7B, 7'h7C,
                            7'h7E, 7'h7F, 7'h10};
      logic [7:0] e [9] = '{8'h00, 8'hFA, 8'h40, 8'h00, 8'h25, 8'h45,
                            8'h19, 8'h00, 8'h00};
      for (int i = 0; i < 9; i++)
         rc(a[i], e[i]);
      chk("offset", {6'h00, lro}, 8'h02);
      chk("gradient", {6'h00, lrg}, 8'h01);
      host.wr(OFS_LIN_REGION, 8'hFF);
      rc(OFS_LIN_REGION, 8'h07);
      chk("offset", {6'h00, lro}, 8'h03);
      chk("gradient", {6'h00, lrg}, 8'h02);
      $display("done reset values");
   endtask : t_reset
   // Every swap and invert combination, a distinct X delta each pass
   task automatic t_orient;
      logic signed [7:0] x, y, ex, ey;
      for (int o = 0; o < 8; o++)
      begin
         x = 8'(5 + o);
         y = -8'sd3;
         host.wr(OFS_ORIENT, {3'(o), 5'h00});
         frame(x, y, 16'hFFFF, 8'h00);
         ex = o[2] ? y : x;
         ey = o[2] ? x : y;
         if (o[0]) ex = -ex;
         if (o[1]) ey = -ey;
         outs(ex, ey);
      end
      $display("done orientation");
   endtask : t_orient
   // Threshold boundary, then shutter cut-off boundary
   task automatic t_motion;
      host.wr(OFS_ORIENT, 8'h00);
      host.wr(OFS_MOTION_IRQ, 8'h07);
      frame(4, -4, 16'hFFFF, 8'h00);
      outs(4, -4);
      frame(3, 4, 16'hFFFF, 8'h00);
      outs(4, -4);
      host.wr(OFS_MOTION_IRQ, 8'h00);
      host.wr(OFS_ENGINE_TWO, 8'h02);
      host.wr(OFS_FINGER_CTRL, 8'h20);
      frame(1, 2, 16'h01FF, 8'h00);
      outs(4, -4);
      frame(1, 2, 16'h0200, 8'h00);
      outs(1, 2);
      host.wr(OFS_ENGINE_TWO, 8'h00);
      $display("done motion gating");
   endtask : t_motion
   // Presence with reflect hysteresis; the release makes a single click
   task automatic t_finger;
      host.wr(OFS_FINGER_CTRL, 8'h00);
      host.wr(OFS_ENGINE_TWO, 8'h01);
      qual = 8'h3F;
      frame(0, 0, 16'hFFFF, 8'h90);
      rc(OFS_FINGER_STATE, 8'h3A);
      qual = 8'h40;
      frame(0, 0, 16'hFFFF, 8'h90);
      rc(OFS_FINGER_STATE, 8'h3B);
      rc(OFS_REFLECT, 8'h90);
      frame(0, 0, 16'hFFFF, 8'h69);
      rc(OFS_FINGER_STATE, 8'h3B);
      host.wr(OFS_FINGER_CTRL, 8'h01);
      frame(0, 0, 16'hFFFF, 8'h67);
      rc(OFS_FINGER_STATE, 8'h3B);
      frame(0, 0, 16'hFFFF, 8'h67);
      rc(OFS_FINGER_STATE, 8'h3A);
      rc(OFS_CLICK_FLAGS, 8'h01);
      chk("irq count", 8'(irq_n), 8'h01);
      host.wr(OFS_CLICK_FLAGS, 8'h00);
      rc(OFS_CLICK_FLAGS, 8'h00);
      host.wr(OFS_FINGER_CTRL, 8'h00);
      $display("done presence and click");
   endtask : t_finger
   // Single disabled: a tap flags nothing; a long touch flags hold
   task automatic t_hold;
      repeat (200) @(negedge clk);
      host.wr(OFS_CLICK_CTRL, 8'h24);
      frame(0, 0, 16'hFFFF, 8'h90);
      frame(0, 0, 16'hFFFF, 8'h10);
      rc(OFS_CLICK_FLAGS, 8'h00);
      frame(0, 0, 16'hFFFF, 8'h90);
      repeat (200) @(negedge clk);
      // Motion above twice the level restarts the hold timer
      frame(3, 2, 16'hFFFF, 8'h90);
      repeat (120) @(negedge clk);
      rc(OFS_CLICK_FLAGS, 8'h00);
      repeat (200) @(negedge clk);
      rc(OFS_CLICK_FLAGS, 8'h04);
      chk("irq count", 8'(irq_n), 8'h02);
      $display("done hold");
   endtask : t_hold
   // Two quick taps give single then double; a moving tap gives nothing
   task automatic t_double;
      frame(0, 0, 16'hFFFF, 8'h10);
      host.wr(OFS_CLICK_FLAGS, 8'h00);
      host.wr(OFS_CLICK_CTRL, 8'h23);
      repeat (200) @(negedge clk);
      frame(0, 0, 16'hFFFF, 8'h90);
      frame(0, 0, 16'hFFFF, 8'h10);
      rc(OFS_CLICK_FLAGS, 8'h01);
      frame(0, 0, 16'hFFFF, 8'h90);
      frame(0, 0, 16'hFFFF, 8'h10);
      rc(OFS_CLICK_FLAGS, 8'h03);
      host.wr(OFS_CLICK_FLAGS, 8'h00);
      frame(0, 0, 16'hFFFF, 8'h90);
      frame(20, 20, 16'hFFFF, 8'h90);
      frame(0, 0, 16'hFFFF, 8'h10);
      rc(OFS_CLICK_FLAGS, 8'h00);
      chk("irq count", 8'(irq_n), 8'h04);
      $display("done double click");
   endtask : t_double
   task automatic test_done;
      $display("checks %0d mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : test_done
   // ==================================================
   // Main sequence and hang limit
   initial
   begin
      repeat (5) @(negedge clk);
      reset = 1'b0;
      t_reset;
      t_orient;
      t_motion;
      t_finger;
      t_hold;
      t_double;
      test_done;
   end
   initial
   begin
      repeat (20000) @(posedge clk);
      err_total++;
      test_done;
   end
endmodule : test_finger_sensor_event_config
`default_nettype wire
